//--- src/smseq_pkg.sv
package smseq_pkg;
  // Register byte offsets
  localparam logic [3:0] SYSCTL1_OFF = 4'h0;
  localparam logic [3:0] WUCTL_OFF = 4'h4;
  localparam logic [3:0] WUCNT_OFF = 4'h8;
  localparam logic [3:0] STATUS_OFF = 4'hc;
  // Fields of system_control_one
  localparam int STOP_BIT = 7;
  localparam int RELSEL_BIT = 6;
  localparam int PHOLD_BIT = 5;
  // Fields of warmup_control_reg
  localparam int WCLKSEL_BIT = 0;
  localparam int KEYLVL_BIT = 1;
  localparam int VDRST_BIT = 2;
  localparam int OSCSRC_BIT = 3;
  // Reset values
  localparam logic [7:0] SYSCTL1_RST = 8'h00;
  localparam logic [7:0] WUCTL_RST = 8'h00;
  localparam logic [7:0] WUCNT_RST = 8'h00;
  // Machine cycle: cycles of the clock that release events are masked after stop entry
  localparam logic [1:0] MCYC_CYCLES = 2'h1;
  // Source-clock divide ratios for warm-up counting
  localparam logic [7:0] HF_DIV = 8'h04;
  localparam logic [7:0] LF_DIV = 8'hff;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
  typedef enum logic [1:0] {ST_RUN, ST_STOP, ST_WARM} smseq_state_e;
endpackage

//--- src/smseq_top.sv
// Functional notes
// [R1] Writing stop bit one enters stop
// [R2] Stop halts both oscillators and operation
// [R3] Memory, registers, status word held
// [R4] Port latches follow hold-enable bit
// [R5] Entry clears prescaler and divider
// [R6] Program counter holds address plus two
// [R7] Reset exits stop, warm-up, single-clock run (reset goes straight to ST_RUN here, with no warm-up count)
// [R8] Wake pin, key wakeup, voltage detect release
// [R9] Release select: one level, zero edge
// [R10] Level mode: pin high releases
// [R11] Level mode: request ignored when pin high
// [R12] Level release: no re-entry on pin low
// [R13] Edge mode: rising edge releases
// [R14] Edge mode: enter even with pin high
// [R15] Edge within one machine cycle ignored
// [R16] Key input at chosen level releases
// [R17] Key release: no re-entry on reversal
// [R18] Voltage reset mode: low supply resets
// [R19] Supply recovery in first cycle ignored
// [R20] Warm-up uses entry oscillator, ignores select
// [R21] Software disables interrupts around stop
// [R22] Operation halted throughout warm-up
// [R23] Resume after request, dividers cleared
// [R24] Warm-up counts source periods to programmed value
`timescale 1ns/100ps
module smseq_top
  import smseq_pkg::*;
(
  // Clock and reset
  input wire logic MCLK_I,
  input wire logic RST_N_I,
  // AXI4-Lite slave
  input wire logic [3:0] AWADDR_I,
  input wire logic AWVALID_I,
  output logic AWREADY_O,
  input wire logic [31:0] WDATA_I,
  input wire logic [3:0] WSTRB_I,
  input wire logic WVALID_I,
  output logic WREADY_O,
  output logic [1:0] BRESP_O,
  output logic BVALID_O,
  input wire logic BREADY_I,
  input wire logic [3:0] ARADDR_I,
  input wire logic ARVALID_I,
  output logic ARREADY_O,
  output logic [31:0] RDATA_O,
  output logic [1:0] RRESP_O,
  output logic RVALID_O,
  input wire logic RREADY_I,
  // Wake sources and system clock source indication
  input wire logic STOP_WAKE_I,
  input wire logic KEY_WAKE_I,
  input wire logic VDET_LOW_I,
  input wire logic HF_SYSCLK_I,
  // Core interface
  input wire logic [15:0] CORE_PC_I,
  output logic [15:0] HOLD_PC_O,
  output logic CORE_HALT_O,
  output logic HF_OSC_EN_O,
  output logic LF_OSC_EN_O,
  output logic TG_CLEAR_O,
  output logic PORT_HOLD_O,
  output logic VDET_RESET_O,
  output logic SINGLE_CLOCK_RUN_O
);
  logic rst_s1_r, rst_n_r;
  logic [7:0] sysctl_r, wuctl_r, wucnt_r;
  smseq_state_e state_r;
  logic [1:0] mask_cnt_r;
  logic wake_d_r, entry_hf_r;
  logic [7:0] div_r, warm_cnt_r;
  logic aw_got_r, w_got_r;
  logic [3:0] aw_addr_r;
  logic [7:0] w_data_r;
  logic stop_wr, wr_fire, src_tick, release_ev;
  logic level_mode;

  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rst_s1_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r <= rst_s1_r;
    end
  end

  // Write channel: address and data taken in either order
  assign wr_fire = aw_got_r && w_got_r && !BVALID_O;
  always_ff @(posedge MCLK_I or negedge rst_n_r) begin
    if (!rst_n_r) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      aw_addr_r <= 4'h0;
      w_data_r <= 8'h00;
      AWREADY_O <= 1'b0;
      WREADY_O <= 1'b0;
      BVALID_O <= 1'b0;
      BRESP_O <= AXI_OKAY;
    end else begin
      AWREADY_O <= !aw_got_r && !AWREADY_O && AWVALID_I;
      WREADY_O <= !w_got_r && !WREADY_O && WVALID_I;
      if (AWVALID_I && AWREADY_O) begin
        aw_got_r <= 1'b1;
        aw_addr_r <= AWADDR_I;
      end
      if (WVALID_I && WREADY_O) begin
        w_got_r <= 1'b1;
        w_data_r <= WSTRB_I[0] ? WDATA_I[7:0] : 8'h00;
      end
      if (wr_fire) begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        BVALID_O <= 1'b1;
        BRESP_O <= (aw_addr_r == SYSCTL1_OFF || aw_addr_r == WUCTL_OFF ||
          aw_addr_r == WUCNT_OFF) ? AXI_OKAY : AXI_SLVERR;
      end else if (BREADY_I) begin
        BVALID_O <= 1'b0;
      end
    end
  end

  assign level_mode = sysctl_r[RELSEL_BIT];
  // Stop request: ignored in level mode when the pin is high
  assign stop_wr = wr_fire && aw_addr_r == SYSCTL1_OFF &&
    w_data_r[STOP_BIT] && !(w_data_r[RELSEL_BIT] && STOP_WAKE_I); // R1 R11 R14

  always_ff @(posedge MCLK_I or negedge rst_n_r) begin
    if (!rst_n_r) begin
      sysctl_r <= SYSCTL1_RST;
      wuctl_r <= WUCTL_RST;
      wucnt_r <= WUCNT_RST;
    end else if (wr_fire) begin
      case (aw_addr_r)
        SYSCTL1_OFF: begin
          sysctl_r <= {stop_wr, w_data_r[6:0]};
        end
        WUCTL_OFF: begin
          wuctl_r <= w_data_r;
        end
        WUCNT_OFF: begin
          wucnt_r <= w_data_r;
        end
        default: begin
        end
      endcase
    end else if (state_r == ST_WARM && release_ev) begin
      sysctl_r[STOP_BIT] <= 1'b0;
    end
  end

  // Read channel
  always_ff @(posedge MCLK_I or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ARREADY_O <= 1'b0;
      RVALID_O <= 1'b0;
      RDATA_O <= 32'h0;
      RRESP_O <= AXI_OKAY;
    end else begin
      ARREADY_O <= ARVALID_I && !ARREADY_O && !RVALID_O;
      if (ARVALID_I && ARREADY_O) begin
        RVALID_O <= 1'b1;
        RRESP_O <= AXI_OKAY;
        case (ARADDR_I)
          SYSCTL1_OFF: RDATA_O <= {24'h0, sysctl_r};
          WUCTL_OFF: RDATA_O <= {24'h0, wuctl_r};
          WUCNT_OFF: RDATA_O <= {24'h0, wucnt_r};
          STATUS_OFF: RDATA_O <= {22'h0, state_r, warm_cnt_r};
          default: begin
            RDATA_O <= 32'h0;
            RRESP_O <= AXI_SLVERR;
          end
        endcase
      end else if (RREADY_I) begin
        RVALID_O <= 1'b0;
      end
    end
  end

  // Stop-state sequencing
  logic pin_ok, key_ok, vd_ok, wake_rise;
  assign wake_rise = STOP_WAKE_I && !wake_d_r;
  assign pin_ok = level_mode ? STOP_WAKE_I : wake_rise; // R9 R10 R13
  assign key_ok = KEY_WAKE_I == wuctl_r[KEYLVL_BIT]; // R16
  assign vd_ok = VDET_LOW_I && wuctl_r[VDRST_BIT]; // R18
  // Events in the first machine cycle after entry are masked
  assign release_ev = (warm_cnt_r >= wucnt_r) && src_tick; // R24

  always_ff @(posedge MCLK_I or negedge rst_n_r) begin
    if (!rst_n_r) begin
      state_r <= ST_RUN;
      mask_cnt_r <= 2'h0;
      wake_d_r <= 1'b0;
      entry_hf_r <= 1'b1;
      HOLD_PC_O <= 16'h0;
    end else begin
      wake_d_r <= STOP_WAKE_I;
      case (state_r)
        ST_RUN: begin
          if (stop_wr) begin
            state_r <= ST_STOP; // R1
            mask_cnt_r <= MCYC_CYCLES;
            entry_hf_r <= HF_SYSCLK_I;
            HOLD_PC_O <= CORE_PC_I + 16'h2; // R6
          end
        end
        ST_STOP: begin
          if (mask_cnt_r != 2'h0) begin
            mask_cnt_r <= mask_cnt_r - 2'h1; // R15 R19
          end else if (vd_ok || pin_ok || key_ok) begin
            state_r <= ST_WARM; // R8
          end
        end
        ST_WARM: begin
          if (release_ev) begin
            state_r <= ST_RUN; // R12 R17 R23
          end
        end
        default: state_r <= ST_RUN;
      endcase
    end
  end

  // Warm-up counting on the oscillator in use at entry
  always_ff @(posedge MCLK_I or negedge rst_n_r) begin
    if (!rst_n_r) begin
      div_r <= 8'h0;
      warm_cnt_r <= 8'h0;
    end else if (state_r != ST_WARM) begin
      div_r <= 8'h0;
      warm_cnt_r <= 8'h0;
    end else if (src_tick) begin
      div_r <= 8'h0;
      warm_cnt_r <= warm_cnt_r + 8'h1; // R24
    end else begin
      div_r <= div_r + 8'h1;
    end
  end
  assign src_tick = div_r == (entry_hf_r ? HF_DIV : LF_DIV); // R20

  always_ff @(posedge MCLK_I or negedge rst_n_r) begin
    if (!rst_n_r) begin
      CORE_HALT_O <= 1'b1;
      HF_OSC_EN_O <= 1'b0;
      LF_OSC_EN_O <= 1'b0;
      TG_CLEAR_O <= 1'b1;
      PORT_HOLD_O <= 1'b0;
      VDET_RESET_O <= 1'b0;
      SINGLE_CLOCK_RUN_O <= 1'b1;
    end else begin
      CORE_HALT_O <= state_r != ST_RUN || stop_wr; // R2 R3 R22
      HF_OSC_EN_O <= state_r != ST_STOP && !stop_wr; // R2
      LF_OSC_EN_O <= state_r != ST_STOP && !stop_wr; // R2
      TG_CLEAR_O <= stop_wr || state_r != ST_RUN; // R5 R23
      PORT_HOLD_O <= (state_r != ST_RUN || stop_wr) &&
        sysctl_r[PHOLD_BIT]; // R4
      VDET_RESET_O <= state_r == ST_STOP && mask_cnt_r == 2'h0 &&
        vd_ok; // R18 R7
      SINGLE_CLOCK_RUN_O <= 1'b1; // R7
    end
  end

  property p_run_osc;
    @(posedge MCLK_I) disable iff (!rst_n_r)
      state_r == ST_RUN && !stop_wr |=> HF_OSC_EN_O && LF_OSC_EN_O;
  endproperty
  a_run_osc: assert property (p_run_osc) else $error("osc off in run"); // R2
  property p_pin_lvl;
    @(posedge MCLK_I) disable iff (!rst_n_r)
      (state_r == ST_STOP && mask_cnt_r == 2'h0 && level_mode &&
        STOP_WAKE_I) |=> state_r == ST_WARM;
  endproperty
  a_pin_lvl: assert property (p_pin_lvl) else $error("no level wake"); // R10
  property p_pin_edge;
    @(posedge MCLK_I) disable iff (!rst_n_r)
      (state_r == ST_STOP && mask_cnt_r == 2'h0 && !level_mode &&
        wake_rise) |=> state_r == ST_WARM;
  endproperty
  a_pin_edge: assert property (p_pin_edge) else $error("no edge wake"); // R13
  property p_key;
    @(posedge MCLK_I) disable iff (!rst_n_r)
      (state_r == ST_STOP && mask_cnt_r == 2'h0 && key_ok) |=>
        state_r == ST_WARM;
  endproperty
  a_key: assert property (p_key) else $error("no key wake"); // R16
  property p_vd;
    @(posedge MCLK_I) disable iff (!rst_n_r)
      (state_r == ST_STOP && mask_cnt_r == 2'h0 && vd_ok) |=>
        VDET_RESET_O && state_r == ST_WARM;
  endproperty
  a_vd: assert property (p_vd) else $error("no voltage reset"); // R18
  property p_edge;
    @(posedge MCLK_I) disable iff (!rst_n_r)
      (wr_fire && aw_addr_r == SYSCTL1_OFF && w_data_r[STOP_BIT] &&
        !w_data_r[RELSEL_BIT] && state_r == ST_RUN) |=> state_r == ST_STOP;
  endproperty
  a_edge: assert property (p_edge) else $error("edge mode not entered"); // R14
  property p_mask;
    @(posedge MCLK_I) disable iff (!rst_n_r)
      stop_wr && state_r == ST_RUN |=> mask_cnt_r == MCYC_CYCLES;
  endproperty
  a_mask: assert property (p_mask) else $error("mask not armed"); // R15 R19
  property p_noreent;
    @(posedge MCLK_I) disable iff (!rst_n_r)
      state_r == ST_WARM |=> state_r != ST_STOP;
  endproperty
  a_noreent: assert property (p_noreent) else $error("re-entered"); // R12 R17
  property p_resume;
    @(posedge MCLK_I) disable iff (!rst_n_r)
      state_r == ST_WARM && release_ev && !wr_fire |=>
        state_r == ST_RUN && !sysctl_r[STOP_BIT];
  endproperty
  a_resume: assert property (p_resume) else $error("no resume"); // R23
  property p_tg_warm;
    @(posedge MCLK_I) disable iff (!rst_n_r)
      state_r != ST_RUN |=> TG_CLEAR_O;
  endproperty
  a_tg_warm: assert property (p_tg_warm) else $error("tg ran"); // R5 R23
  property p_hold;
    @(posedge MCLK_I) disable iff (!rst_n_r)
      state_r != ST_RUN |=> PORT_HOLD_O == $past(sysctl_r[PHOLD_BIT]);
  endproperty
  a_hold: assert property (p_hold) else $error("port hold wrong"); // R4
  property p_pc_keep;
    @(posedge MCLK_I) disable iff (!rst_n_r)
      state_r == ST_STOP |=> $stable(HOLD_PC_O);
  endproperty
  a_pc_keep: assert property (p_pc_keep) else $error("pc moved"); // R3 R6
  property p_regs;
    @(posedge MCLK_I) disable iff (!rst_n_r)
      state_r == ST_STOP && !wr_fire |=> $stable(wuctl_r) && $stable(wucnt_r);
  endproperty
  a_regs: assert property (p_regs) else $error("registers moved"); // R3
  property p_cnt_start;
    @(posedge MCLK_I) disable iff (!rst_n_r)
      state_r != ST_WARM |=> div_r == 8'h0 && warm_cnt_r == 8'h0;
  endproperty
  a_cnt_start: assert property (p_cnt_start) else $error("count dirty"); // R24
  property p_cnt_step;
    @(posedge MCLK_I) disable iff (!rst_n_r)
      state_r == ST_WARM && src_tick && !release_ev |=>
        warm_cnt_r == $past(warm_cnt_r) + 8'h1;
  endproperty
  a_cnt_step: assert property (p_cnt_step) else $error("count stuck"); // R24
  property p_entry_src;
    @(posedge MCLK_I) disable iff (!rst_n_r)
      stop_wr && state_r == ST_RUN |=> entry_hf_r == $past(HF_SYSCLK_I);
  endproperty
  a_entry_src: assert property (p_entry_src) else $error("bad source"); // R20
  property p_entry;
    @(posedge MCLK_I) disable iff (!rst_n_r)
      stop_wr |=> state_r == ST_STOP;
  endproperty
  a_entry: assert property (p_entry) else $error("no stop entry"); // R1
  property p_halt;
    @(posedge MCLK_I) disable iff (!rst_n_r)
      state_r == ST_WARM |=> CORE_HALT_O;
  endproperty
  a_halt: assert property (p_halt) else $error("core ran in warm-up"); // R22
  property p_ign;
    @(posedge MCLK_I) disable iff (!rst_n_r)
      (state_r == ST_STOP && mask_cnt_r != 2'h0) |=> state_r == ST_STOP;
  endproperty
  a_ign: assert property (p_ign) else $error("early release"); // R15
  property p_lvl;
    @(posedge MCLK_I) disable iff (!rst_n_r)
      (wr_fire && aw_addr_r == SYSCTL1_OFF && w_data_r[RELSEL_BIT] &&
        STOP_WAKE_I && state_r == ST_RUN) |=> state_r == ST_RUN;
  endproperty
  a_lvl: assert property (p_lvl) else $error("entered with pin high"); // R11
  property p_osc;
    @(posedge MCLK_I) disable iff (!rst_n_r)
      state_r == ST_STOP |=> !HF_OSC_EN_O && !LF_OSC_EN_O;
  endproperty
  a_osc: assert property (p_osc) else $error("oscillator ran"); // R2
  property p_warm;
    @(posedge MCLK_I) disable iff (!rst_n_r)
      state_r == ST_WARM && !release_ev |=> state_r == ST_WARM;
  endproperty
  a_warm: assert property (p_warm) else $error("warm-up left"); // R12
  property p_pc;
    @(posedge MCLK_I) disable iff (!rst_n_r)
      stop_wr |=> HOLD_PC_O == $past(CORE_PC_I) + 16'h2;
  endproperty
  a_pc: assert property (p_pc) else $error("bad held pc"); // R6
  property p_tg;
    @(posedge MCLK_I) disable iff (!rst_n_r)
      stop_wr |=> TG_CLEAR_O;
  endproperty
  a_tg: assert property (p_tg) else $error("divider not cleared"); // R5
endmodule

//--- tb/smseq_wake_model.sv
`timescale 1ns/100ps
module smseq_wake_model (
  // Bench commands
  input wire logic clk_i,
  input wire logic pin_i,
  input wire logic key_i,
  input wire logic vlow_i,
  // Wake lines to the sequencer
  output logic stop_wake_o,
  output logic key_wake_o,
  output logic vdet_low_o
);
  initial begin
    stop_wake_o = 1'b0;
    key_wake_o = 1'b0;
    vdet_low_o = 1'b0;
  end
  // Pads are driven from outside, so they change a cycle after the command
  always @(posedge clk_i) begin
    stop_wake_o <= pin_i;
    key_wake_o <= key_i;
    vdet_low_o <= vlow_i;
  end
endmodule

//--- tb/stop_mode_sequencer_bench.sv
`timescale 1ns/100ps
module stop_mode_sequencer_bench;
  import smseq_pkg::*;
  logic clk = 0, rst_n = 0, pin = 0, key = 1, vlow = 0, wk, kw, vl;
  logic hfsys = 1;
  logic [3:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rd;
  logic awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
  logic awr, wr, bv, arr, rv, halt, hfe, lfe, tgc, ph, vrst, scr;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [15:0] pc = 16'h1234, hpc;
  int errors = 0, comparisons = 0, n;
  // Rows: release_mode_select, pin level, expected halt
  logic [2:0] rows [4] = '{3'b101, 3'b110, 3'b011, 3'b001};
  always #10 clk = ~clk;
  smseq_wake_model partner (.clk_i(clk), .pin_i(pin), .key_i(key),
    .vlow_i(vlow), .stop_wake_o(wk), .key_wake_o(kw), .vdet_low_o(vl));
  smseq_top uut (.MCLK_I(clk), .RST_N_I(rst_n), .AWADDR_I(awaddr),
    .AWVALID_I(awv), .AWREADY_O(awr), .WDATA_I(wdata), .WSTRB_I(4'hf),
    .WVALID_I(wv), .WREADY_O(wr), .BRESP_O(bresp), .BVALID_O(bv),
    .BREADY_I(bry), .ARADDR_I(araddr), .ARVALID_I(arv), .ARREADY_O(arr),
    .RDATA_O(rdata), .RRESP_O(rresp), .RVALID_O(rv), .RREADY_I(rry),
    .STOP_WAKE_I(wk), .KEY_WAKE_I(kw), .VDET_LOW_I(vl), .HF_SYSCLK_I(hfsys),
    .CORE_PC_I(pc), .HOLD_PC_O(hpc), .CORE_HALT_O(halt),
    .HF_OSC_EN_O(hfe), .LF_OSC_EN_O(lfe), .TG_CLEAR_O(tgc),
    .PORT_HOLD_O(ph), .VDET_RESET_O(vrst), .SINGLE_CLOCK_RUN_O(scr));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    logic aw = 0, w = 0;
    @(posedge clk);
    awaddr <= a; wdata <= {24'h0, d}; awv <= 1; wv <= 1; bry <= 1;
    while (!(aw && w)) begin
      @(posedge clk);
      if (awr) begin aw = 1; awv <= 0; end
      if (wr) begin w = 1; wv <= 0; end
    end
    while (bv !== 1'b1) @(posedge clk);
    bry <= 0;
  endtask
  task automatic rd_reg(input logic [3:0] a);
    @(posedge clk);
    araddr <= a; arv <= 1; rry <= 1;
    do @(posedge clk); while (arr !== 1'b1);
    arv <= 0;
    while (rv !== 1'b1) @(posedge clk);
    rd = rdata;
    rry <= 0;
  endtask
  task automatic wait_run(input int lim);
    n = 0;
    while (halt !== 1'b0 && n < lim) begin @(posedge clk); n++; end
    chk(halt, 0);
    chk(hfe, 1);
  endtask
  task automatic stop_req(input logic release_mode_select);
    wr_reg(SYSCTL1_OFF, {1'b1, release_mode_select, 6'h20});
    repeat (4) @(posedge clk);
  endtask
  task end_sim();
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    end_sim();
  end
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1;
    repeat (3) @(posedge clk);
    foreach (rows[i]) begin
      rd_reg(SYSCTL1_OFF + 4'(4 * i));
      chk(rd, 0);
    end
    chk(scr, 1);
    wr_reg(WUCNT_OFF, 8'h03);
    foreach (rows[i]) begin
      pc <= 16'h1234;
      pin <= rows[i][1];
      repeat (3) @(posedge clk);
      stop_req(rows[i][2]);
      pc <= 16'habcd;
      chk(halt, rows[i][0]);
      if (rows[i][0]) begin
        chk({hfe, lfe, tgc, ph}, 4'b0011);
        chk(hpc, 16'h1236);
        pin <= 0;
        repeat (4) @(posedge clk);
        chk(halt, 1);
        pin <= 1;
        repeat (3) @(posedge clk);
        pin <= 0;
        wait_run(300);
        chk(n > 10, 1);
        repeat (5) @(posedge clk);
        chk(halt, 0);
      end
      rd_reg(SYSCTL1_OFF);
      chk(rd, {24'h0, 1'b0, rows[i][2], 6'h20});
    end
    for (int l = 0; l < 2; l++) begin
      key <= !l[0];
      wr_reg(WUCTL_OFF, {6'h0, l[0], 1'b0});
      stop_req(0);
      chk(halt, 1);
      key <= l[0];
      repeat (3) @(posedge clk);
      key <= !l[0];
      wait_run(300);
    end
    wr_reg(WUCTL_OFF, 8'h06);
    stop_req(0);
    vlow <= 1;
    n = 0;
    while (vrst !== 1'b1 && n < 20) begin @(posedge clk); n++; end
    chk(vrst, 1);
    vlow <= 0;
    wait_run(300);
    hfsys <= 0;
    wr_reg(WUCNT_OFF, 8'h01);
    stop_req(0);
    pin <= 1;
    wait_run(1000);
    chk(n > 500, 1);
    pin <= 0;
    rst_n <= 0;
    @(posedge clk);
    chk({halt, hfe, tgc}, 3'b101);
    rst_n <= 1;
    repeat (3) @(posedge clk);
    rd_reg(SYSCTL1_OFF);
    chk(rd, 0);
    rd_reg(WUCNT_OFF);
    chk(rd, 0);
    end_sim();
  end
endmodule
